// File: src/conv_update_pkg.sv
// Constants, register map and value packing for the converter update logic
package conv_update_pkg;

   // Register addresses on the plain register port
   localparam int ADDR_W = 2;
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_HIGH = 2'h1;
   localparam logic [1:0] ADDR_LOW = 2'h2;

   // Control register field positions
   localparam int CTRL_AUTO_BIT = 7;
   localparam int CTRL_TSEL_MSB = 6;
   localparam int CTRL_TSEL_LSB = 4;
   localparam int CTRL_ALIGN_BIT = 2;
   localparam int CTRL_ON_BIT = 0;
   localparam logic [7:0] CTRL_WMASK = 8'hF5;

   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] HIGH_RESET = 8'h00;
   localparam logic [7:0] LOW_RESET = 8'h00;
   localparam logic [9:0] SHADOW_RESET = 10'h000;

   // Trigger source codes
   localparam logic [2:0] TSEL_CMP0 = 3'h0;
   localparam logic [2:0] TSEL_CMP1 = 3'h1;
   localparam logic [2:0] TSEL_EXT0 = 3'h2;
   localparam logic [2:0] TSEL_TMR1_OVF = 3'h6;
   localparam logic [2:0] TSEL_TMR1_CAP = 3'h7;

   // Conversion (settling) time after each shadow update
   localparam int CLK_PERIOD_NS = 25;
   localparam int CONV_TIME_NS = 1000;
   localparam int CONV_CYCLES =
      (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_CNT_W = 8;

   // Packs the two data bytes into the 10-bit value
   function automatic logic [9:0] pack_value(input logic left,
                                             input logic [7:0] high,
                                             input logic [7:0] low);
      if (left) begin
         pack_value = {high, low[7:6]};
      end else begin
         pack_value = {high[1:0], low};
      end
   endfunction : pack_value

endpackage : conv_update_pkg

// File: src/trigger_edge_detect.sv
// Trigger source selection and rising-edge detection
`timescale 1ns/100ps
module trigger_edge_detect (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [2:0] i_sel,
   input wire logic i_cmp0_flag,
   input wire logic i_cmp1_flag,
   input wire logic i_ext0_flag,
   input wire logic i_tmr1_ovf_flag,
   input wire logic i_tmr1_cap_flag,
   output logic o_level,
   output logic o_edge
);
   import conv_update_pkg::*;

   logic prev_q;

   // Flags are taken raw, whatever their interrupt enables say
   always_comb begin
      case (i_sel)
         TSEL_CMP0: o_level = i_cmp0_flag;
         TSEL_CMP1: o_level = i_cmp1_flag;
         TSEL_EXT0: o_level = i_ext0_flag;
         TSEL_TMR1_OVF: o_level = i_tmr1_ovf_flag;
         TSEL_TMR1_CAP: o_level = i_tmr1_cap_flag;
         default: o_level = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= o_level;
      end
   end

   // A flag held high gives one edge only
   assign o_edge = o_level && !prev_q;

   chk_edge_fresh: assert property (@(posedge i_clk) disable iff (i_rst)
      o_edge |=> !o_edge)
      else $error("edge reported twice for one flag rise");

endmodule : trigger_edge_detect

// File: src/conv_update_ctrl.sv
// Converter input registers, shadow update and trigger handling
//
// Summary of operation
// - Ten-bit value held as high and low bytes
// - Control: auto, select, align, enable; reserved zero
// - Enable bit switches the converter on
// - Auto mode updates on selected trigger rise
// - Held-high trigger needs a fresh rise
// - Rises during a conversion are dropped
// - Trigger is raw flag rise, enables ignored
// - Select codes map to five event sources
// - Selection matters only in auto mode
// - Analog stage sees hidden shadow value only
// - Manual mode: high byte write updates shadow
// - Low write blocks updates until high write
// - High-only use refreshes at every trigger
// - Alignment maps value bits into bytes
// - Alignment change acts at next high write
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
module conv_update_ctrl #(
   parameter int CONV_CYCLES_P = conv_update_pkg::CONV_CYCLES
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   input wire logic [conv_update_pkg::ADDR_W-1:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   input wire logic I_CMP0_FLAG,
   input wire logic I_CMP1_FLAG,
   input wire logic I_EXT0_FLAG,
   input wire logic I_TMR1_OVF_FLAG,
   input wire logic I_TMR1_CAP_FLAG,
   output logic [9:0] O_CONV_VALUE,
   output logic O_CONV_ENABLE,
   output logic O_CONV_BUSY,
   output logic O_CONV_UPDATE
);
   import conv_update_pkg::*;

   if (CONV_CYCLES_P < 1 || CONV_CYCLES_P >= (1 << BUSY_CNT_W)) begin : g_chk
      $error("CONV_CYCLES_P out of range for the busy counter");
   end

   localparam logic [BUSY_CNT_W-1:0] BUSY_LOAD =
      BUSY_CNT_W'(CONV_CYCLES_P);

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] conv_control_q;
   logic [7:0] conv_value_high_q;
   logic [7:0] conv_value_low_q;
   logic low_pending_q;
   logic align_latched_q;
   logic [9:0] shadow_q;
   logic [9:0] shadow_d;
   logic [BUSY_CNT_W-1:0] busy_cnt_q;
   logic [7:0] rdata_q;
   logic update_q;

   logic auto_trigger_on;
   logic [2:0] trigger_select;
   logic left_align;
   logic converter_on;
   logic wr_ctrl;
   logic wr_high;
   logic wr_low;
   logic busy;
   logic trig_level;
   logic trig_edge;
   logic manual_upd;
   logic auto_upd;

   assign auto_trigger_on = conv_control_q[CTRL_AUTO_BIT];
   assign trigger_select = conv_control_q[CTRL_TSEL_MSB:CTRL_TSEL_LSB];
   assign left_align = conv_control_q[CTRL_ALIGN_BIT];
   assign converter_on = conv_control_q[CTRL_ON_BIT];

   assign wr_ctrl = I_WR && (I_ADDR == ADDR_CTRL);
   assign wr_high = I_WR && (I_ADDR == ADDR_HIGH);
   assign wr_low = I_WR && (I_ADDR == ADDR_LOW);
   assign busy = (busy_cnt_q != '0);

   ////////////////////////////////////////////////////////////////////////
   // Software-visible registers
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         conv_control_q <= CTRL_RESET;
      end else if (wr_ctrl) begin
         conv_control_q <= I_WDATA & CTRL_WMASK;
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         conv_value_high_q <= HIGH_RESET;
         conv_value_low_q <= LOW_RESET;
      end else begin
         if (wr_high) begin
            conv_value_high_q <= I_WDATA;
         end
         if (wr_low) begin
            conv_value_low_q <= I_WDATA;
         end
      end
   end

   // Low write arms the block; only the high write lifts it
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         low_pending_q <= 1'b0;
      end else if (wr_low) begin
         low_pending_q <= 1'b1;
      end else if (wr_high) begin
         low_pending_q <= 1'b0;
      end
   end

   // Alignment is frozen at each high write
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         align_latched_q <= 1'b0;
      end else if (wr_high) begin
         align_latched_q <= left_align;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Trigger source
   trigger_edge_detect u_trig (
      .i_clk(I_CLK_SYS),
      .i_rst(I_RST),
      .i_sel(trigger_select),
      .i_cmp0_flag(I_CMP0_FLAG),
      .i_cmp1_flag(I_CMP1_FLAG),
      .i_ext0_flag(I_EXT0_FLAG),
      .i_tmr1_ovf_flag(I_TMR1_OVF_FLAG),
      .i_tmr1_cap_flag(I_TMR1_CAP_FLAG),
      .o_level(trig_level),
      .o_edge(trig_edge)
   );

   ////////////////////////////////////////////////////////////////////////
   // Shadow update
   // Manual writes are never refused: software owns the pace there
   assign manual_upd = wr_high && !auto_trigger_on;
   // The flag is not queued: a rise seen while busy is simply lost
   assign auto_upd = auto_trigger_on && trig_edge && !busy
                     && !low_pending_q;

   always_comb begin
      shadow_d = shadow_q;
      if (manual_upd) begin
         shadow_d = pack_value(left_align, I_WDATA,
                               conv_value_low_q);
      end else if (auto_upd) begin
         shadow_d = pack_value(align_latched_q, conv_value_high_q,
                               conv_value_low_q);
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         shadow_q <= SHADOW_RESET;
      end else begin
         shadow_q <= shadow_d;
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         update_q <= 1'b0;
      end else begin
         update_q <= manual_upd || auto_upd;
      end
   end

   // Conversion in progress after each update
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         busy_cnt_q <= '0;
      end else if (manual_upd || auto_upd) begin
         busy_cnt_q <= BUSY_LOAD;
      end else if (busy) begin
         busy_cnt_q <= busy_cnt_q - 1'b1;
      end
   end

   assign O_CONV_VALUE = shadow_q;
   assign O_CONV_ENABLE = converter_on;
   assign O_CONV_BUSY = busy;
   assign O_CONV_UPDATE = update_q;

   ////////////////////////////////////////////////////////////////////////
   // Read port: data stand one cycle after the strobe, only then
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         rdata_q <= 8'h00;
      end else if (I_RD) begin
         case (I_ADDR)
            ADDR_CTRL: rdata_q <= conv_control_q;
            ADDR_HIGH: rdata_q <= conv_value_high_q;
            ADDR_LOW: rdata_q <= conv_value_low_q;
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign O_RDATA = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RST);

   chk_ctrl_reserved: assert property (
      I_RD && I_ADDR == ADDR_CTRL |=> O_RDATA[3] == 1'b0
         && O_RDATA[1] == 1'b0)
      else $error("reserved control bits read non-zero");

   chk_enable_write: assert property (
      wr_ctrl |=> O_CONV_ENABLE == $past(I_WDATA[CTRL_ON_BIT]))
      else $error("converter enable does not follow control write");

   chk_manual_update: assert property (
      wr_high && !auto_trigger_on |=> O_CONV_VALUE == pack_value(
         $past(left_align), $past(I_WDATA), $past(conv_value_low_q)))
      else $error("high write did not load shadow in manual mode");

   chk_auto_update: assert property (
      auto_trigger_on && trig_edge && !busy && !low_pending_q
         && !wr_high |=> O_CONV_VALUE == pack_value($past(align_latched_q),
         $past(conv_value_high_q), $past(conv_value_low_q)))
      else $error("trigger rise did not load shadow");

   chk_pending_block: assert property (
      low_pending_q && !(wr_high && !auto_trigger_on)
         |=> $stable(O_CONV_VALUE))
      else $error("shadow changed before high byte was written");

   chk_busy_ignore: assert property (
      busy && !wr_high |=> $stable(O_CONV_VALUE))
      else $error("trigger accepted during conversion");

   chk_select_ignored: assert property (
      !auto_trigger_on && !wr_high |=> $stable(O_CONV_VALUE))
      else $error("shadow changed without high write in manual mode");

   chk_align_deferred: assert property (
      wr_ctrl && !wr_high ##1 !wr_high[*2] |-> $stable(align_latched_q))
      else $error("alignment applied before next high write");

   chk_busy_length: assert property (
      O_CONV_UPDATE |-> busy_cnt_q == BUSY_LOAD)
      else $error("conversion time not loaded on update");

   chk_reset_zero: assert property (@(posedge I_CLK_SYS)
      $past(I_RST) |-> O_CONV_VALUE == SHADOW_RESET)
      else $error("shadow not zero after reset");

   ////////////////////////////////////////////////////////////////////////
   // Conversion timing and trigger filtering
   chk_update_marks: assert property (
      manual_upd || auto_upd |=> O_CONV_UPDATE && O_CONV_BUSY)
      else $error("shadow load not followed by update pulse and busy");

   chk_busy_countdown: assert property (
      busy && !manual_upd && !auto_upd
         |=> busy_cnt_q == $past(busy_cnt_q) - 1'b1)
      else $error("conversion counter skipped a step");

   chk_low_arms: assert property (
      wr_low |=> low_pending_q && !auto_upd)
      else $error("low byte write did not hold back updates");

   chk_align_latch: assert property (
      wr_high |=> align_latched_q == $past(left_align))
      else $error("alignment not captured at high write");

   // Reserved codes have no source behind them, so no edge may appear
   chk_reserved_quiet: assert property (
      trigger_select == 3'h3 || trigger_select == 3'h4
         || trigger_select == 3'h5 |-> !trig_edge)
      else $error("reserved trigger code produced an edge");

   // A flag left high past the end of a conversion must not reload
   chk_held_no_retrig: assert property (
      busy && trig_level ##1 trig_level && $stable(trigger_select)
         |-> !auto_upd)
      else $error("held trigger flag started a new conversion");

   cov_held_flag: cover property (
      busy && trig_level ##1 !busy && trig_level);

   cov_manual: cover property (wr_high && !auto_trigger_on);
   cov_auto: cover property (auto_upd);
   cov_busy_drop: cover property (auto_trigger_on && trig_edge && busy);
   cov_pending_drop: cover property (
      auto_trigger_on && trig_edge && low_pending_q && !busy);

endmodule : conv_update_ctrl

// File: sim/event_source_model.sv
// Behavioural event flag sources on the far side of the trigger inputs
`timescale 1ns/100ps
module event_source_model (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [4:0] i_set,
   input wire logic [4:0] i_clr,
   output logic [4:0] o_flags
);
   /////////////////////////////////////////////////////////////////////////
   // A flag stays set until software clears it, so a new trigger needs a
   // fresh rise; the flag is set with no regard to any interrupt enable
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_flags <= 5'h00;
      end else begin
         o_flags <= (o_flags & ~i_clr) | i_set;
      end
   end
endmodule : event_source_model

// File: sim/tb.sv
// Self-checking bench for the converter update control block
`timescale 1ns/100ps
module tb;
   import conv_update_pkg::*;
   localparam int CONV_N = 6;
   logic clk = 1'b0;
   logic rst, wr_en, rd_en;
   logic [1:0] addr;
   logic [7:0] wdata, rdata;
   logic [4:0] set, clr, flags;
   logic [9:0] value;
   logic conv_on, busy, upd;
   integer fail_count = 0, cmp_count = 0, upd_count = 0, busy_cycles = 0;
   integer m_high, m_low, m_ctrl, m_align, m_pend, m_val, m_upd, v, s, k;

   always #12.5 clk = ~clk;
   always @(posedge clk) if (upd === 1'b1) upd_count <= upd_count + 1;
   always @(posedge clk) if (busy === 1'b1) busy_cycles <= busy_cycles + 1;

   conv_update_ctrl #(.CONV_CYCLES_P(CONV_N)) conv_update_ctrl_inst (
      .I_CLK_SYS(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr_en), .I_RD(rd_en), .O_RDATA(rdata),
      .I_CMP0_FLAG(flags[0]), .I_CMP1_FLAG(flags[1]),
      .I_EXT0_FLAG(flags[2]), .I_TMR1_OVF_FLAG(flags[3]),
      .I_TMR1_CAP_FLAG(flags[4]), .O_CONV_VALUE(value),
      .O_CONV_ENABLE(conv_on), .O_CONV_BUSY(busy), .O_CONV_UPDATE(upd));
   event_source_model event_source_model_inst (.i_clk(clk), .i_rst(rst),
      .i_set(set), .i_clr(clr), .o_flags(flags));

   /////////////////////////////////////////////////////////////////////////
   task stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
      end
   endtask : chk

   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // Reference value built from the stored bytes and latched alignment
   task m_load;
      if (m_align != 0) m_val = ((m_high << 2) | (m_low >> 6)) & 1023;
      else m_val = ((m_high & 3) << 8) | m_low;
      m_upd = m_upd + 1;
   endtask : m_load

   task m_trig(input int hit);
      if (hit != 0 && (m_ctrl & 128) != 0 && m_pend == 0) m_load;
   endtask : m_trig

   task bus_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      if (a == 2'h0) m_ctrl = d & 8'hF5;
      if (a == 2'h2) begin
         m_low = d;
         m_pend = 1;
      end
      if (a == 2'h1) begin
         m_high = d;
         m_pend = 0;
         m_align = (m_ctrl >> 2) & 1;
         if ((m_ctrl & 128) == 0) m_load;
      end
      #1;
      if (a == 2'h1 && (m_ctrl & 128) == 0) begin
         chk(value, m_val);
         chk(upd, 1);
         chk(busy, 1);
      end
   endtask : bus_wr

   task bus_rd(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(rdata, exp);
      @(posedge clk);
      #1 chk(rdata, 8'h00);
   endtask : bus_rd

   task settle;
      tick(CONV_N + 6);
      #1;
      chk(value, m_val);
      chk(upd_count, m_upd);
      chk(busy, 0);
      chk(busy_cycles, m_upd * CONV_N);
   endtask : settle

   task raise(input int i);
      @(posedge clk);
      set <= 5'h01 << i;
      @(posedge clk);
      set <= 5'h00;
   endtask : raise

   task clear_all;
      @(posedge clk);
      clr <= 5'h1F;
      @(posedge clk);
      clr <= 5'h00;
      tick(1);
   endtask : clear_all

   function int src_of(input int code);
      case (code)
         0, 1, 2: src_of = code;
         6: src_of = 3;
         7: src_of = 4;
         default: src_of = -1;
      endcase
   endfunction : src_of

   initial begin
      tick(20000);
      fail_count = fail_count + 1;
      stop_test;
   end

   initial begin
      rst = 1'b1; addr = 2'h0; wdata = 8'h00; wr_en = 1'b0; rd_en = 1'b0;
      set = 5'h00; clr = 5'h00;
      m_high = 0; m_low = 0; m_ctrl = 0; m_align = 0; m_pend = 0;
      m_val = 0; m_upd = 0;
      tick(5);
      rst <= 1'b0;
      void'($urandom(57139));
      for (k = 0; k < 4; k++) bus_rd(2'(k), 8'h00);
      chk(value, 0);
      bus_wr(2'h0, 8'hFF);
      bus_rd(2'h0, 8'hF5);
      chk(conv_on, 1);
      bus_wr(2'h3, 8'hFF);
      bus_rd(2'h3, 8'h00);
      bus_wr(2'h0, 8'h01);
      for (k = 0; k < 4; k++) begin
         v = $urandom % 1024;
         bus_wr(2'h2, 8'(v));
         bus_wr(2'h1, 8'(v >> 8));
         settle();
         chk(value, v);
      end
      bus_wr(2'h0, 8'h05);
      settle();
      v = $urandom % 1024;
      bus_wr(2'h1, 8'(v >> 2));
      settle();
      for (k = 0; k < 5; k++) begin
         raise(k);
         settle();
         clear_all;
      end
      for (s = 0; s < 8; s++) begin
         bus_wr(2'h0, 8'(128 | (s << 4) | 5));
         bus_wr(2'h1, 8'($urandom));
         settle();
         for (k = 0; k < 5; k++) begin
            raise(k);
            m_trig(src_of(s) == k);
            settle();
            clear_all;
         end
      end
      bus_wr(2'h0, 8'h81);
      bus_wr(2'h2, 8'($urandom));
      raise(0);
      settle();
      clear_all;
      bus_wr(2'h1, 8'($urandom));
      raise(0);
      m_trig(1);
      settle();
      clear_all;
      raise(0);
      m_trig(1);
      @(posedge clk);
      clr <= 5'h01;
      @(posedge clk);
      clr <= 5'h00;
      raise(0);
      settle();
      clear_all;
      raise(0);
      m_trig(1);
      settle();
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      m_high = 0;
      m_low = 0;
      m_ctrl = 0;
      m_align = 0;
      m_pend = 0;
      m_val = 0;
      #1 chk(value, 0);
      chk(conv_on, 0);
      chk(busy, 0);
      bus_wr(2'h0, 8'h01);
      chk(conv_on, 1);
      bus_wr(2'h0, 8'h00);
      chk(conv_on, 0);
      stop_test;
   end
endmodule : tb
